// ==== dv/osc_source_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Oscillator sources seen by the clock select block
// ****************************************************************
module osc_source_model (
  input  wire logic       hclk,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] half,
  output logic            rc_osc,
  output logic            xtal_osc,
  output logic            int_osc,
  output logic            rise
);
  logic [7:0] cnt;
  logic       lvl;

  // The level flips every half cycles; half must stay at 1 or more, or the level flips only every 256 cycles.
  always @(posedge hclk) begin
    if (!run) begin
      cnt  <= 8'h00;
      lvl  <= 1'b0;
      rise <= 1'b0;
    end else if (cnt == half - 8'h01) begin
      cnt  <= 8'h00;
      lvl  <= !lvl;
      rise <= !lvl;
    end else begin
      cnt  <= cnt + 8'h01;
      rise <= 1'b0;
    end
  end

  // Only the chosen source runs; stopped parts rest low, as a dead oscillator would.
  assign rc_osc   = lvl & (sel == 2'h0);
  assign xtal_osc = lvl & (sel == 2'h1);
  assign int_osc  = lvl & (sel == 2'h2);
endmodule

// ==== dv/test_oscillator_mode_pll_select.sv ====
`timescale 1ns/1ps
module test_oscillator_mode_pll_select;
  import osc_select_pkg::*;
  typedef struct packed {
    logic [3:0]  mode;
    logic [1:0]  src;
    logic        en;
    logic [31:0] ticks;
    logic [7:0]  stat;
  } row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, run, rise;
  logic        rc_osc, xtal_osc, int_osc, pin_i, pin_o, pin_oe, tick;
  logic [7:0]  haddr, half;
  logic [1:0]  htrans, src;
  logic [2:0]  hsize;
  logic [3:0]  cfg;
  logic [31:0] hwdata, hrdata, q, t, g;
  row_t        rows [8];
  int          bad_count;
  int          comparisons;

  // ****************************************************************
  // Design, far side and clock
  // ****************************************************************
  osc_mode_select dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .osc_select_config(cfg), .rc_osc_in(rc_osc),
    .crystal_osc_in(xtal_osc), .internal_osc_in(int_osc), .osc_out_pin_i(pin_i),
    .osc_out_pin_o(pin_o), .osc_out_pin_oe(pin_oe), .sys_clk_tick(tick));
  osc_source_model src_model (.hclk(hclk), .run(run), .sel(src), .half(half), .rc_osc(rc_osc),
    .xtal_osc(xtal_osc), .int_osc(int_osc), .rise(rise));

  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single word transfer; the request is held until hready is seen high.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // The strap is only taken after reset, so each mode needs a fresh reset.
  task automatic do_reset(input logic [3:0] c);
    run     <= 1'b0;
    cfg     <= c;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    check("reset outputs", 32'h0, {hrdata[26:0], hreadyout, hresp, tick, pin_o, pin_oe});
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask

  // Counts ticks and pin changes over eight source periods, after six periods to lock.
  task automatic measure(output logic [31:0] tk, output logic [31:0] tg);
    int   n;
    logic p;
    n = 0;
    tk = 0;
    tg = 0;
    while (n < 6) begin
      @(posedge hclk);
      if (rise === 1'b1) n++;
    end
    n = 0;
    p = pin_o;
    while (n < 8) begin
      @(posedge hclk);
      if (tick === 1'b1) tk++;
      if (pin_o !== p) tg++;
      p = pin_o;
      if (rise === 1'b1) n++;
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {hsel, hwrite, run, pin_i, haddr, htrans, src, cfg, hwdata} = '0;
    hsize = 3'h2;
    half  = 8'h04;
    bad_count = 0;
    comparisons = 0;
    rows = '{'{rc_mode, 2'h0, 1'b0, 32'h8, 8'h87}, '{rc_gpio_mode, 2'h0, 1'b0, 32'h8, 8'h84},
      '{high_speed_crystal_mode, 2'h1, 1'b1, 32'h8, 8'h82}, '{crystal_pll_mode, 2'h1, 1'b0, 32'h20, 8'hB6},
      '{crystal_pll_mode, 2'h1, 1'b1, 32'h20, 8'hB6}, '{internal_osc_block, 2'h2, 1'b0, 32'h8, 8'h88},
      '{internal_osc_block, 2'h2, 1'b1, 32'h20, 8'hB8}, '{4'hF, 2'h1, 1'b1, 32'h8, 8'h8F}};
    // Each row sets a mode, runs its source and checks the clock rate and status.
    foreach (rows[i]) begin
      do_reset(rows[i].mode);
      ahb(1'b1, CTRL_OFFSET, {31'h0, rows[i].en}, q);
      src <= rows[i].src;
      run <= 1'b1;
      measure(t, g);
      check("ticks", rows[i].ticks, t);
      ahb(1'b0, STATUS_OFFSET, 32'h0, q);
      check("status", {24'h0, rows[i].stat}, {24'h0, q[7:0]});
      if (rows[i].src == 2'h0) begin
        check("pin toggles", (rows[i].mode == rc_mode) ? 32'h4 : 32'h0, g);
        check("pin enable", {31'h0, rows[i].mode == rc_mode}, {31'h0, pin_oe});
      end
    end
    // A strap change after the latch must not move the mode.
    cfg <= rc_mode;
    repeat (4) @(posedge hclk);
    ahb(1'b0, STATUS_OFFSET, 32'h0, q);
    check("late strap", 32'h8F, {24'h0, q[7:0]});
    // Software turns the internal multiplier on, then off again.
    do_reset(internal_osc_block);
    ahb(1'b1, CTRL_OFFSET, 32'h1, q);
    src <= 2'h2;
    run <= 1'b1;
    measure(t, g);
    check("pll on ticks", 32'h20, t);
    ahb(1'b1, CTRL_OFFSET, 32'h0, q);
    measure(t, g);
    check("pll off ticks", 32'h8, t);
    // Register access, an unmapped place and the freed pin as a port bit.
    do_reset(rc_gpio_mode);
    ahb(1'b0, CTRL_OFFSET, 32'h0, q);
    check("ctrl reset", {31'h0, CTRL_RESET}, q);
    ahb(1'b0, PORT_DIR_OFFSET, 32'h0, q);
    check("dir reset", 32'h0, q);
    ahb(1'b1, CTRL_OFFSET, 32'h1, q);
    ahb(1'b0, CTRL_OFFSET, 32'h0, q);
    check("ctrl rw", 32'h1, q);
    ahb(1'b1, 8'h10, 32'hFFFFFFFF, q);
    ahb(1'b0, 8'h10, 32'h0, q);
    check("unmapped", 32'h0, q);
    ahb(1'b1, PORT_DIR_OFFSET, 32'h40, q);
    ahb(1'b1, PORT_OFFSET, 32'h40, q);
    repeat (2) @(posedge hclk);
    check("pin drive", 32'h3, {30'h0, pin_oe, pin_o});
    pin_i <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, PORT_OFFSET, 32'h0, q);
    check("port read", 32'h40, q & 32'h40);
    test_done;
  end

  // The whole run needs some thirteen hundred cycles; this cuts off a hang.
  initial begin
    repeat (30000) @(posedge hclk);
    bad_count++;
    test_done;
  end
endmodule

// ==== src/edge_multiplier.sv ====
`timescale 1ns/1ps
module edge_multiplier #(
  parameter int unsigned CNT_W     = 12,
  parameter int unsigned MULT_LOG2 = 2
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             enable,
  input  wire logic             src_edge,
  output logic                  tick,
  output logic                  locked,
  output logic [CNT_W-1:0]      period
);
  import osc_select_pkg::*;

  localparam int unsigned PULSES = 1 << MULT_LOG2;

  if (CNT_W < 4 || MULT_LOG2 < 1 || MULT_LOG2 > 4) begin : g_check
    $error("edge_multiplier: unsupported width or factor");
  end

  logic [CNT_W-1:0]     elapsed;
  logic [CNT_W-1:0]     phase;
  logic [MULT_LOG2:0]   left;
  logic [1:0]           seen;
  logic [CNT_W-1:0]     next_elapsed;
  logic [CNT_W-1:0]     next_phase;
  logic [MULT_LOG2:0]   next_left;
  logic [1:0]           next_seen;
  logic [CNT_W-1:0]     next_period;
  logic                 next_tick;
  logic [CNT_W-1:0]     step;

  // ****************************************************************
  // Period measure and spread of multiplied edges
  // ****************************************************************
  // The source period is measured in hclk cycles and each period is cut into equal steps.
  // The remainder of the division is dropped, so the last step of a period runs long.
  assign step = ((period >> MULT_LOG2) == '0) ? CNT_W'(1) : (period >> MULT_LOG2);

  always_comb begin
    next_elapsed = (elapsed == '1) ? elapsed : elapsed + CNT_W'(1);
    next_phase   = phase;
    next_left    = left;
    next_seen    = seen;
    next_period  = period;
    next_tick    = 1'b0;
    if (!enable) begin
      next_seen = 2'h0;
      next_left = '0;
    end else if (src_edge) begin
      next_period  = elapsed;
      next_elapsed = CNT_W'(1);
      next_phase   = '0;
      next_left    = (MULT_LOG2 + 1)'(PULSES - 1);
      next_seen    = (seen == 2'h3) ? seen : seen + 2'h1;
      next_tick    = locked;
    end else if (left != '0) begin
      next_phase = phase + CNT_W'(1);
      if (next_phase >= step) begin
        next_phase = '0;
        next_left  = left - (MULT_LOG2 + 1)'(1);
        next_tick  = locked;
      end
    end
  end

  assign locked = (seen >= 2'h2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      elapsed <= '0;
      phase   <= '0;
      left    <= '0;
      seen    <= 2'h0;
      period  <= '0;
      tick    <= 1'b0;
    end else begin
      elapsed <= next_elapsed;
      phase   <= next_phase;
      left    <= next_left;
      seen    <= next_seen;
      period  <= next_period;
      tick    <= next_tick;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_locked_edge_tick : assert property (@(posedge hclk) disable iff (!hresetn)
    enable && locked && src_edge |=> tick)
    else $error("locked source edge gave no multiplied tick");

endmodule

// ==== src/osc_mode_select.sv ====
`timescale 1ns/1ps
module osc_mode_select #(
  parameter int unsigned PERIOD_BITS = osc_select_pkg::PERIOD_W
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [3:0]  osc_select_config,
  input  wire logic        rc_osc_in,
  input  wire logic        crystal_osc_in,
  input  wire logic        internal_osc_in,
  input  wire logic        osc_out_pin_i,
  output logic             osc_out_pin_o,
  output logic             osc_out_pin_oe,
  output logic             sys_clk_tick
);
  import osc_select_pkg::*;

  if (PERIOD_BITS < 4) begin : g_check
    $error("osc_mode_select: period counter too narrow");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Stage one feeds only stage two; the third stage exists for edge detection.
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [2:0] sync3;
  logic [3:0] cfg_sync1;
  logic [3:0] cfg_sync2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1     <= 4'h0;
      sync2     <= 4'h0;
      sync3     <= 3'h0;
      cfg_sync1 <= 4'h0;
      cfg_sync2 <= 4'h0;
    end else begin
      sync1     <= {osc_out_pin_i, internal_osc_in, crystal_osc_in, rc_osc_in};
      sync2     <= sync1;
      sync3     <= sync2[2:0];
      cfg_sync1 <= osc_select_config;
      cfg_sync2 <= cfg_sync1;
    end
  end

  logic rc_edge;
  logic xtal_edge;
  logic int_osc_edge;
  assign rc_edge      = sync2[0] && !sync3[0];
  assign xtal_edge    = sync2[1] && !sync3[1];
  assign int_osc_edge = sync2[2] && !sync3[2];

  // ****************************************************************
  // Configuration capture
  // ****************************************************************
  // The strap is taken once, after the synchroniser has settled, and then held until reset.
  logic [3:0] mode;
  logic [1:0] settle;
  logic       cfg_done;
  logic [3:0] next_mode;
  logic [1:0] next_settle;
  logic       next_cfg_done;

  always_comb begin
    next_mode     = mode;
    next_settle   = settle;
    next_cfg_done = cfg_done;
    if (!cfg_done) begin
      if (settle == 2'(CFG_SETTLE_CYCLES)) begin
        next_mode     = cfg_sync2;
        next_cfg_done = 1'b1;
      end else begin
        next_settle = settle + 2'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode     <= 4'h0;
      settle   <= 2'h0;
      cfg_done <= 1'b0;
    end else begin
      mode     <= next_mode;
      settle   <= next_settle;
      cfg_done <= next_cfg_done;
    end
  end

  logic is_rc;
  logic is_rc_gpio;
  logic is_xpll;
  logic is_int_osc;
  assign is_rc      = cfg_done && (mode == rc_mode);
  assign is_rc_gpio = cfg_done && (mode == rc_gpio_mode);
  assign is_xpll    = cfg_done && (mode == crystal_pll_mode);
  assign is_int_osc = cfg_done && (mode == internal_osc_block);

  // ****************************************************************
  // AHB-Lite register slave
  // ****************************************************************
  // Zero wait states: read data is fetched at the address phase and stands in the data phase.
  logic        pll_en;
  logic        port_latch;
  logic        port_dir;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        next_pll_en;
  logic        next_port_latch;
  logic        next_port_dir;
  logic        next_wr_pend;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_hrdata;
  logic        pll_on;
  logic        pll_locked;
  logic        freq_fault;
  logic        take;

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == 3'h2);

  always_comb begin
    next_pll_en     = pll_en;
    next_port_latch = port_latch;
    next_port_dir   = port_dir;
    next_wr_pend    = take && hwrite;
    next_wr_addr    = take ? haddr : wr_addr;
    next_hrdata     = 32'h0000_0000;
    if (wr_pend) begin
      unique case (wr_addr)
        CTRL_OFFSET:     next_pll_en     = hwdata[CTRL_PLL_EN_BIT];
        PORT_OFFSET:     next_port_latch = hwdata[PORT_BIT];
        PORT_DIR_OFFSET: next_port_dir   = hwdata[PORT_BIT];
        default:         next_pll_en     = pll_en;
      endcase
    end
    if (take && !hwrite) begin
      unique case (haddr)
        CTRL_OFFSET:     next_hrdata[CTRL_PLL_EN_BIT] = pll_en;
        STATUS_OFFSET:   next_hrdata = {24'h00_0000, cfg_done, freq_fault, pll_locked, pll_on, mode};
        PORT_OFFSET:     next_hrdata[PORT_BIT] = is_rc_gpio ? sync2[3] : 1'b0;
        PORT_DIR_OFFSET: next_hrdata[PORT_BIT] = port_dir;
        default:         next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_en     <= CTRL_RESET;
      port_latch <= PORT_RESET;
      port_dir   <= PORT_DIR_RESET;
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b0;
      hresp      <= 1'b0;
    end else begin
      pll_en     <= next_pll_en;
      port_latch <= next_port_latch;
      port_dir   <= next_port_dir;
      wr_pend    <= next_wr_pend;
      wr_addr    <= next_wr_addr;
      hrdata     <= next_hrdata;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  // ****************************************************************
  // PLL path selection
  // ****************************************************************
  // The software enable is looked at only for the internal oscillator; any code other than
  // the crystal PLL code leaves the crystal path unmultiplied.
  logic                   src_edge;
  logic                   pll_tick;
  logic [PERIOD_BITS-1:0] src_period;

  assign pll_on   = is_xpll || (is_int_osc && pll_en);
  assign src_edge = (is_rc || is_rc_gpio) ? rc_edge : (is_int_osc ? int_osc_edge : (cfg_done && xtal_edge));

  edge_multiplier #(
    .CNT_W     (PERIOD_BITS),
    .MULT_LOG2 (PLL_MULT_LOG2)
  ) u_mult (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .enable   (pll_on),
    .src_edge (src_edge),
    .tick     (pll_tick),
    .locked   (pll_locked),
    .period   (src_period)
  );

  // A source faster than the limit allows would push the product past its ceiling, so the
  // multiplied edges are withheld and the system clock gets no ticks at all.
  assign freq_fault = pll_on && pll_locked &&
                      (src_period < (is_int_osc ? PERIOD_BITS'(INT_OSC_MIN_PERIOD) : PERIOD_BITS'(XTAL_MIN_PERIOD)));

  // ****************************************************************
  // System clock and oscillator pin
  // ****************************************************************
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic       next_sys_tick;
  logic       next_pin_o;
  logic       next_pin_oe;

  always_comb begin
    next_div_cnt  = (is_rc || is_rc_gpio) && rc_edge ? div_cnt + 2'h1 : div_cnt;
    next_sys_tick = (pll_on && !freq_fault && pll_locked) ? pll_tick : (!pll_on && src_edge);
    next_pin_o    = 1'b0;
    next_pin_oe   = 1'b0;
    if (is_rc) begin
      next_pin_o  = next_div_cnt[1];
      next_pin_oe = 1'b1;
    end else if (is_rc_gpio) begin
      next_pin_o  = port_latch;
      next_pin_oe = port_dir;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt        <= 2'h0;
      sys_clk_tick   <= 1'b0;
      osc_out_pin_o  <= 1'b0;
      osc_out_pin_oe <= 1'b0;
    end else begin
      div_cnt        <= next_div_cnt;
      sys_clk_tick   <= next_sys_tick;
      osc_out_pin_o  <= next_pin_o;
      osc_out_pin_oe <= next_pin_oe;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_xtal_pll_forced : assert property (@(posedge hclk) disable iff (!hresetn)
    is_xpll |-> pll_on)
    else $error("crystal PLL mode left the PLL off");
  a_int_osc_soft_gate : assert property (@(posedge hclk) disable iff (!hresetn)
    is_int_osc |-> (pll_on == pll_en))
    else $error("internal oscillator PLL not following software enable");
  a_other_bypass : assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_done && !is_xpll && !is_int_osc |-> !pll_on)
    else $error("PLL on for a non-PLL oscillator code");
  a_rc_pin_drive : assert property (@(posedge hclk) disable iff (!hresetn)
    is_rc && rc_edge && (div_cnt == 2'h1) |=> osc_out_pin_oe && osc_out_pin_o)
    else $error("RC divide-by-four output missing");
  a_rc_pin_low : assert property (@(posedge hclk) disable iff (!hresetn)
    is_rc && rc_edge && (div_cnt == 2'h3) |=> !osc_out_pin_o)
    else $error("RC divide-by-four output not falling");
  a_gpio_release : assert property (@(posedge hclk) disable iff (!hresetn)
    is_rc_gpio && $stable(port_dir) |=> (osc_out_pin_oe == $past(port_dir)))
    else $error("RC gpio mode pin enable not from port direction");
  a_gpio_latch_drive : assert property (@(posedge hclk) disable iff (!hresetn)
    is_rc_gpio |=> (osc_out_pin_o == $past(port_latch)))
    else $error("RC gpio mode pin value not from port latch");
  a_bypass_pass : assert property (@(posedge hclk) disable iff (!hresetn)
    !pll_on && src_edge |=> sys_clk_tick)
    else $error("unmultiplied source edge not passed through");
  // Once locked and inside its limit, every multiplied edge must reach the system clock.
  a_pll_tick_pass : assert property (@(posedge hclk) disable iff (!hresetn)
    pll_on && pll_locked && !freq_fault && pll_tick |=> sys_clk_tick)
    else $error("multiplied tick not passed to the system clock");
  a_config_held : assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_done |=> cfg_done && $stable(mode))
    else $error("latched oscillator select changed");
  a_limit_guard : assert property (@(posedge hclk) disable iff (!hresetn)
    freq_fault && !src_edge |=> !sys_clk_tick)
    else $error("multiplied edge issued beyond frequency limit");

  // Main scenarios: divided pin, crystal lock, software enable, freed pin and plain bypass.
  c_rc_divide     : cover property (@(posedge hclk) disable iff (!hresetn) is_rc && $rose(osc_out_pin_o));
  c_xtal_locked   : cover property (@(posedge hclk) disable iff (!hresetn) is_xpll && pll_locked && pll_tick);
  c_int_osc_pll   : cover property (@(posedge hclk) disable iff (!hresetn) is_int_osc && $rose(pll_en));
  c_rc_gpio_drive : cover property (@(posedge hclk) disable iff (!hresetn) is_rc_gpio && osc_out_pin_oe);
  c_bypass_tick   : cover property (@(posedge hclk) disable iff (!hresetn) cfg_done && !pll_on && sys_clk_tick);

endmodule

// ==== src/osc_select_pkg.sv ====
package osc_select_pkg;

  // ****************************************************************
  // Clock and frequency limits
  // ****************************************************************
  localparam int unsigned HCLK_HZ           = 10_000_000;
  localparam int unsigned PLL_MULT          = 4;
  localparam int unsigned PLL_MULT_LOG2     = 2;
  localparam int unsigned XTAL_PLL_IN_MAX_HZ = 10_000_000;
  localparam int unsigned XTAL_PLL_OUT_MAX_HZ = 40_000_000;
  localparam int unsigned INT_OSC_PLL_OUT_MAX_HZ = 32_000_000;
  // Least source period, in hclk cycles, that keeps the multiplied clock inside its limit.
  localparam int unsigned XTAL_MIN_PERIOD   = (PLL_MULT * HCLK_HZ + XTAL_PLL_OUT_MAX_HZ - 1) / XTAL_PLL_OUT_MAX_HZ;
  localparam int unsigned INT_OSC_MIN_PERIOD = (PLL_MULT * HCLK_HZ + INT_OSC_PLL_OUT_MAX_HZ - 1) / INT_OSC_PLL_OUT_MAX_HZ;
  localparam int unsigned PERIOD_W          = 12;
  localparam int unsigned CFG_SETTLE_CYCLES = 2;
  localparam int unsigned PORT_BIT          = 6;

  // ****************************************************************
  // Oscillator select encodings
  // ****************************************************************
  typedef enum logic [3:0] {
    rc_mode                 = 4'h7,
    rc_gpio_mode            = 4'h4,
    high_speed_crystal_mode = 4'h2,
    crystal_pll_mode        = 4'h6,
    internal_osc_block      = 4'h8
  } osc_mode_t;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] STATUS_OFFSET   = 8'h04;
  localparam logic [7:0] PORT_OFFSET     = 8'h08;
  localparam logic [7:0] PORT_DIR_OFFSET = 8'h0C;
  localparam int unsigned CTRL_PLL_EN_BIT  = 0;
  localparam int unsigned STAT_PLL_ON_BIT  = 4;
  localparam int unsigned STAT_LOCK_BIT    = 5;
  localparam int unsigned STAT_FAULT_BIT   = 6;
  localparam int unsigned STAT_CFG_BIT     = 7;
  localparam logic CTRL_RESET     = 1'b0;
  localparam logic PORT_RESET     = 1'b0;
  localparam logic PORT_DIR_RESET = 1'b0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage
